// [logic/sees_map.svh]
// Register indices, field positions and reset values of the block
`ifndef SEES_MAP_SVH
`define SEES_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SEES_IDX_ST_A 10'h012
`define SEES_IDX_ST_B 10'h013
`define SEES_IDX_ST_C 10'h014
`define SEES_IDX_ST_D 10'h015
`define SEES_IDX_EN_A 10'h018
`define SEES_IDX_EN_B 10'h019
`define SEES_IDX_EN_C 10'h01a
`define SEES_IDX_EN_D 10'h01b
`define SEES_IDX_EDGE 10'h01c
`define SEES_IDX_IRQ_STS 10'h020
`define SEES_IDX_IRQ_MASK 10'h021

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEES_EDGE_W 6
`define SEES_IRQ_W 7
`define SEES_IRQ_GROUP_BIT 6
`define SEES_PIN_GPIO_21 5'd1
`define SEES_PIN_GPIO_22 5'd2
`define SEES_PIN_GPIO_60 5'd3
`define SEES_PIN_GPIO_41 5'd12
`define SEES_PIN_GPIO_43 5'd14
`define SEES_PIN_GPIO_61 5'd15
`define SEES_FAN_BIT 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SEES_EN_RST 8'h00
`define SEES_ST_RST 8'h00
`define SEES_EDGE_RST 6'h00
`define SEES_IRQ_STS_RST 7'h00
`define SEES_IRQ_MASK_RST 7'h00

`endif

// [logic/sees_pkg.sv]
// Shared types of the event enable and edge status block
package sees_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [7:0] sees_byte_t;
    typedef logic [9:0] sees_idx_t;

    // Source groups, one enable and one status register each
    typedef enum logic [1:0] {
        SEES_GRP_A = 2'b00,
        SEES_GRP_B = 2'b01,
        SEES_GRP_C = 2'b10,
        SEES_GRP_D = 2'b11
    } sees_grp_e;

    localparam int SEES_NUM_GRP = 4;

endpackage : sees_pkg

// [logic/sees_edge_sync.sv]
// Two-stage pin synchroniser with either-edge detection
`timescale 1ns/1ps

module sees_edge_sync #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] edges
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] prev;
    logic [2:0] primed;

    // ------------------------------------------------------------------
    // Synchroniser and history
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            prev <= '0;
            primed <= 3'h0;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            prev <= stage2;
            primed <= {primed[1:0], 1'b1};
        end
    end

    // Masked until history is filled, so a pin high at reset is no edge
    assign edges = (stage2 ^ prev) & {WIDTH{primed[2]}};

endmodule : sees_edge_sync

// [logic/sees_top.sv]
// Event source enable, per-source status and edge status with APB access
//
// Notes on behaviour
// R1: Enable group A at 0x18 gates gpio_20..27 (gpio_60 at bit 3) to group.
// R2: Enable group B at 0x19 gates gpio_30..33,41,fan,43,61 to group.
// R3: Enable group C at 0x1A gates gpio_50 to gpio_57 onto group output.
// R4: Enable group D at 0x1B gates gpio_10 to gpio_17 onto source bus.
// R5: Source bus bit high only when its status and enable are both one.
// R6: Edge status at 0x1C; writing one clears bits 5..0, zero keeps them.
// R7: Edge status bit 0 sets on either edge of gpio_21, sticky.
// R8: Edge status bit 1 sets on either edge of gpio_22.
// R9: Edge status bit 2 sets on either edge of gpio_41.
// R10: Edge status bit 3 sets on either edge of gpio_43.
// R11: Edge status bit 4 sets on either edge of gpio_60.
// R12: Edge status bit 5 sets on either edge of gpio_61.
// R13: Edge status bits 7 and 6 always read zero.
// R14: Each enable bit has a latched status bit, cleared by writing one.
// R15: Group output active while any set status in groups A to C has its enable set.
// R16: Pins synchronised, edge when two synchronised samples differ.
`timescale 1ns/1ps
`include "sees_map.svh"

module sees_top (
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources
    input wire logic [7:0] gpioGroupA,
    input wire logic [6:0] gpioGroupB,
    input wire logic fanSpeedPulseInput,
    input wire logic [7:0] gpioGroupC,
    input wire logic [7:0] gpioGroupD,
    // Outputs
    output logic groupMgmtIrqN,
    output logic [7:0] sourceEventBus,
    output logic irq
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    sees_pkg::sees_byte_t enable [sees_pkg::SEES_NUM_GRP];
    sees_pkg::sees_byte_t srcStatus [sees_pkg::SEES_NUM_GRP];
    logic [`SEES_EDGE_W-1:0] edgeStatus;
    logic [`SEES_IRQ_W-1:0] irqStatus;
    logic [`SEES_IRQ_W-1:0] irqMask;

    // Next values are formed combinationally so the flopped outputs can
    // follow the registers at the same edge, with no cycle of lag
    sees_pkg::sees_byte_t next_enable [sees_pkg::SEES_NUM_GRP];
    sees_pkg::sees_byte_t next_srcStatus [sees_pkg::SEES_NUM_GRP];
    logic [`SEES_EDGE_W-1:0] next_edgeStatus;
    logic [`SEES_IRQ_W-1:0] next_irqStatus;
    logic [`SEES_IRQ_W-1:0] next_irqMask;

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    wire [7:0] groupBPins;
    wire [31:0] allPins;
    wire [31:0] pinEdges;

    // Fan tachometer sits at bit 5 of group B
    assign groupBPins = {gpioGroupB[6:5], fanSpeedPulseInput,
                         gpioGroupB[4:0]};
    // One flat vector keeps pin order equal to status bit order, so
    // group g owns bits g*8 upward
    assign allPins = {gpioGroupD, gpioGroupC, groupBPins, gpioGroupA};

    // Group D shares the synchroniser although it only feeds the bus
    sees_edge_sync #(
        .WIDTH(32)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .pins(allPins),
        .edges(pinEdges) // [R16]
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire [9:0] regIdx;
    wire aligned;
    wire setupPhase;
    wire accessDone;
    wire wrAcc;
    wire rdAcc;
    wire [3:0] hitSt;
    wire [3:0] hitEn;
    wire hitEdge;
    wire hitIrqSts;
    wire hitIrqMask;
    wire mapped;

    // Only whole aligned words decode; data sits in the low byte lane
    assign regIdx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setupPhase = psel & ~penable;
    // pready comes from this block, so completion is our own edge
    assign accessDone = psel & penable & pready;
    assign wrAcc = accessDone & pwrite;
    assign rdAcc = accessDone & ~pwrite;

    assign hitSt[0] = aligned & (regIdx == `SEES_IDX_ST_A);
    assign hitSt[1] = aligned & (regIdx == `SEES_IDX_ST_B);
    assign hitSt[2] = aligned & (regIdx == `SEES_IDX_ST_C);
    assign hitSt[3] = aligned & (regIdx == `SEES_IDX_ST_D);
    assign hitEn[0] = aligned & (regIdx == `SEES_IDX_EN_A); // [R1]
    assign hitEn[1] = aligned & (regIdx == `SEES_IDX_EN_B); // [R2]
    assign hitEn[2] = aligned & (regIdx == `SEES_IDX_EN_C); // [R3]
    assign hitEn[3] = aligned & (regIdx == `SEES_IDX_EN_D); // [R4]
    assign hitEdge = aligned & (regIdx == `SEES_IDX_EDGE); // [R6]
    assign hitIrqSts = aligned & (regIdx == `SEES_IDX_IRQ_STS);
    assign hitIrqMask = aligned & (regIdx == `SEES_IDX_IRQ_MASK);
    assign mapped = (|hitSt) | (|hitEn) | hitEdge | hitIrqSts | hitIrqMask;

    // ------------------------------------------------------------------
    // Per-group enable and latched source status
    // ------------------------------------------------------------------
    sees_pkg::sees_byte_t rdEn [sees_pkg::SEES_NUM_GRP];
    sees_pkg::sees_byte_t rdSt [sees_pkg::SEES_NUM_GRP];
    sees_pkg::sees_byte_t pending [sees_pkg::SEES_NUM_GRP];

    genvar g;
    generate
        for (g = 0; g < sees_pkg::SEES_NUM_GRP; g = g + 1) begin : gen_grp
            wire [7:0] grpEdges;
            wire [7:0] clrMask;

            assign grpEdges = pinEdges[g*8 +: 8];
            assign clrMask = {8{wrAcc & hitSt[g]}} & pwdata[7:0];

            // Disabling a source drops its output at the same edge
            assign next_enable[g] = (wrAcc & hitEn[g]) ? pwdata[7:0]
                                                         : enable[g];
            // A new event in the clearing cycle survives the clear
            assign next_srcStatus[g] = (srcStatus[g] & ~clrMask)
                                       | grpEdges; // [R14]
            assign pending[g] = next_srcStatus[g] & next_enable[g];

            assign rdEn[g] = {8{hitEn[g]}} & enable[g];
            assign rdSt[g] = {8{hitSt[g]}} & srcStatus[g];

            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    enable[g] <= `SEES_EN_RST;
                    srcStatus[g] <= `SEES_ST_RST;
                end else begin
                    enable[g] <= next_enable[g];
                    srcStatus[g] <= next_srcStatus[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Group interrupt and source bus
    // ------------------------------------------------------------------
    wire nextGroupActive;
    wire next_groupMgmtIrqN;
    wire groupRise;
    wire [7:0] nextSourceBus;

    // Group D feeds only the source bus, not the group output
    assign nextGroupActive = |(pending[sees_pkg::SEES_GRP_A]
                               | pending[sees_pkg::SEES_GRP_B]
                               | pending[sees_pkg::SEES_GRP_C]); // [R15]
    assign nextSourceBus = pending[sees_pkg::SEES_GRP_D]; // [R5]
    assign groupRise = nextGroupActive & groupMgmtIrqN;
    // Active low at the pin, so the flop resets to the idle high level
    assign next_groupMgmtIrqN = ~nextGroupActive; // [R15]

    // ------------------------------------------------------------------
    // Edge status
    // ------------------------------------------------------------------
    wire [`SEES_EDGE_W-1:0] edgeSet;
    wire [`SEES_EDGE_W-1:0] edgeClr;

    // Pin feeding each edge status bit, lowest bit first
    localparam int EDGE_PIN [`SEES_EDGE_W] = '{
        `SEES_PIN_GPIO_21, // [R7]
        `SEES_PIN_GPIO_22, // [R8]
        `SEES_PIN_GPIO_41, // [R9]
        `SEES_PIN_GPIO_43, // [R10]
        `SEES_PIN_GPIO_60, // [R11]
        `SEES_PIN_GPIO_61 // [R12]
    };

    // These pins also feed their own source status bits; both views
    // share one synchroniser so they never disagree about an edge
    genvar b;
    generate
        for (b = 0; b < `SEES_EDGE_W; b = b + 1) begin : gen_edge
            assign edgeSet[b] = pinEdges[EDGE_PIN[b]];
        end
    endgenerate

    assign edgeClr = {`SEES_EDGE_W{wrAcc & hitEdge}}
                     & pwdata[`SEES_EDGE_W-1:0]; // [R6]
    // Set wins over a clear in the same cycle, so no edge is lost
    assign next_edgeStatus = (edgeStatus & ~edgeClr) | edgeSet; // [R7]

    // ------------------------------------------------------------------
    // Block interrupt status and mask
    // ------------------------------------------------------------------
    wire [`SEES_IRQ_W-1:0] irqEvents;
    wire [`SEES_IRQ_W-1:0] irqClr;
    wire next_irq;

    assign irqEvents = {groupRise, edgeSet};
    // Clear only what the read returned, so later events are kept
    assign irqClr = {`SEES_IRQ_W{rdAcc & hitIrqSts}}
                    & prdata[`SEES_IRQ_W-1:0];
    assign next_irqStatus = (irqStatus & ~irqClr) | irqEvents;
    assign next_irqMask = (wrAcc & hitIrqMask) ? pwdata[`SEES_IRQ_W-1:0]
                                               : irqMask;
    // Mask applied before the flop so irq and status agree every cycle
    assign next_irq = |(next_irqStatus & next_irqMask);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [7:0] rdGroups;
    wire [7:0] rdEdge;
    wire [7:0] rdIrq;
    wire [31:0] readWord;

    // Unselected registers give zero, so an OR of all of them is the mux
    assign rdGroups = rdEn[0] | rdEn[1] | rdEn[2] | rdEn[3]
                      | rdSt[0] | rdSt[1] | rdSt[2] | rdSt[3];
    assign rdEdge = {8{hitEdge}} & {2'b00, edgeStatus}; // [R13]
    assign rdIrq = ({8{hitIrqSts}} & {1'b0, irqStatus})
                   | ({8{hitIrqMask}} & {1'b0, irqMask});
    assign readWord = {24'h000000, rdGroups | rdEdge | rdIrq};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // No write path here: every change is formed in the next_ logic
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edgeStatus <= `SEES_EDGE_RST;
            irqStatus <= `SEES_IRQ_STS_RST;
            irqMask <= `SEES_IRQ_MASK_RST;
        end else begin
            edgeStatus <= next_edgeStatus;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
        end
    end

    // Outputs follow the registers at the same edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            groupMgmtIrqN <= 1'b1;
            sourceEventBus <= 8'h00;
            irq <= 1'b0;
        end else begin
            groupMgmtIrqN <= next_groupMgmtIrqN; // [R15]
            sourceEventBus <= nextSourceBus; // [R5]
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------------
    wire next_pready;
    wire next_pslverr;
    wire loadRead;
    wire [31:0] next_prdata;

    // Answer in the first access cycle, so a master never waits on us
    assign next_pready = setupPhase;
    // Unaligned and unmapped addresses are refused, never aliased
    assign next_pslverr = setupPhase & ~mapped;
    assign loadRead = setupPhase & ~pwrite;
    // Writes return zero; read data is captured in setup and then held
    assign next_prdata = loadRead ? readWord
                         : (setupPhase ? 32'h00000000 : prdata);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

endmodule : sees_top

// [bench/sees_top_checker.sv]
// Port-level assertions for the event enable and edge status block
`timescale 1ns/1ps

module sees_top_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] gpioGroupA,
    input wire logic [6:0] gpioGroupB,
    input wire logic fanSpeedPulseInput,
    input wire logic [7:0] gpioGroupC,
    input wire logic [7:0] gpioGroupD,
    input wire logic groupMgmtIrqN,
    input wire logic [7:0] sourceEventBus,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    // A pin change is seen at the outputs three sampling ticks later
    sequence pin_chg_s;
        $past(gpioGroupA, 3) != $past(gpioGroupA, 4) ||
        $past(gpioGroupB, 3) != $past(gpioGroupB, 4) ||
        $past(gpioGroupC, 3) != $past(gpioGroupC, 4) ||
        $past(fanSpeedPulseInput, 3) != $past(fanSpeedPulseInput, 4);
    endsequence
    sequence en_wr_s;
        $past(pready) && $past(pwrite) && $past(paddr) >= 12'h060 &&
        $past(paddr) <= 12'h068;
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_ready_one: assert property (setup_s |=> pready ##1 !pready)
        else $error("pready is not a single-cycle answer");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel))
        else $error("pready without a setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    a_unaligned_err: assert property
        ((setup_s ##0 paddr[1:0] != 2'h0) |=> pready && pslverr)
        else $error("unaligned access not refused");
    a_map_ok: assert property ((setup_s ##0 paddr >= 12'h060 &&
        paddr <= 12'h070 && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped register refused");
    a_edge_resv: assert property ((pready && !pwrite &&
        paddr == 12'h070) |-> prdata[31:6] == 26'h0)
        else $error("edge status upper bits not zero");
    a_bus_cause: assert property (|(sourceEventBus & ~$past(sourceEventBus))
        |-> ($past(gpioGroupD, 3) != $past(gpioGroupD, 4)) ||
        ($past(pready) && $past(pwrite) && $past(paddr) == 12'h06c))
        else $error("source bus rose without event or enable");
    a_group_cause: assert property ($fell(groupMgmtIrqN) |->
        pin_chg_s or en_wr_s)
        else $error("group output fell without cause");
    a_group_hold: assert property ($rose(groupMgmtIrqN) |->
        $past(pready) && $past(pwrite))
        else $error("group output released without a write");
endmodule : sees_top_checker

// [bench/sees_top_tb.sv]
// Self-checking testbench of the event enable and edge status block
`timescale 1ns/1ps

module sees_top_tb;
    logic core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, groupMgmtIrqN, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [14:0] pinsAB = 15'h0000;
    logic fanSpeedPulseInput = 1'h0;
    logic [7:0] gpioGroupC = 8'h00, gpioGroupD = 8'h00, sourceEventBus, m, e;
    int miscompares = 0, n_checks = 0, cycles = 0, seed = 32'h62be, k;
    int edgeM = 0;
    int pinIdx[6] = '{1, 2, 12, 13, 3, 14};

    always #5 core_clk = ~core_clk;

    sees_top dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpioGroupA(pinsAB[7:0]), .gpioGroupB(pinsAB[14:8]),
        .fanSpeedPulseInput(fanSpeedPulseInput), .gpioGroupC(gpioGroupC),
        .gpioGroupD(gpioGroupD), .groupMgmtIrqN(groupMgmtIrqN),
        .sourceEventBus(sourceEventBus), .irq(irq));

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Setup, then access until pready; release one edge later
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("ERROR at %0t: timeout", $time);
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge core_clk);
        for (k = 0; k < 5; k++) rdchk(12'h060 + 12'(4 * k), 32'h0);
        for (k = 0; k < 4; k++) begin
            m = 8'($random(seed));
            apb(1'h1, 12'h060 + 12'(4 * k), {24'h0, m});
            rdchk(12'h060 + 12'(4 * k), {24'h0, m});
            apb(1'h1, 12'h060 + 12'(4 * k), 32'h0);
        end
        apb(1'h0, 12'h07c, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        apb(1'h1, 12'h061, 32'hff);
        chk(32'(err), 32'h1);
        $display("test registers done");
        // Each edge source, rising then falling
        for (k = 0; k < 6; k++) begin
            repeat (2) begin
                pinsAB[pinIdx[k]] <= ~pinsAB[pinIdx[k]];
                repeat (6) @(posedge core_clk);
                edgeM = edgeM | (1 << k);
                rdchk(12'h070, 32'(edgeM));
                apb(1'h1, 12'h070, 32'h0);
                rdchk(12'h070, 32'(edgeM));
                apb(1'h1, 12'h070, 32'hff);
                edgeM = 0;
                rdchk(12'h070, 32'h0);
            end
        end
        chk(32'(groupMgmtIrqN), 32'h1);
        rdchk(12'h048, 32'h0e);
        rdchk(12'h04c, 32'hd0);
        apb(1'h1, 12'h060, 32'h02);
        chk(32'(groupMgmtIrqN), 32'h0);
        apb(1'h1, 12'h048, 32'h02);
        chk(32'(groupMgmtIrqN), 32'h1);
        apb(1'h1, 12'h048, 32'hff);
        apb(1'h1, 12'h04c, 32'hff);
        fanSpeedPulseInput <= 1'h1;
        repeat (6) @(posedge core_clk);
        apb(1'h1, 12'h064, 32'h20);
        chk(32'(groupMgmtIrqN), 32'h0);
        apb(1'h1, 12'h04c, 32'h20);
        chk(32'(groupMgmtIrqN), 32'h1);
        m = 8'($random(seed));
        gpioGroupC <= m;
        repeat (6) @(posedge core_clk);
        apb(1'h1, 12'h068, {24'h0, m});
        chk(32'(groupMgmtIrqN), 32'(m == 8'h00));
        apb(1'h1, 12'h050, 32'hff);
        $display("test group output done");
        m = 8'($random(seed));
        e = 8'($random(seed));
        gpioGroupD <= m;
        repeat (6) @(posedge core_clk);
        apb(1'h1, 12'h06c, {24'h0, e});
        chk(32'(sourceEventBus), 32'(m & e));
        apb(1'h1, 12'h054, 32'hff);
        chk(32'(sourceEventBus), 32'h0);
        $display("test source bus done");
        apb(1'h1, 12'h064, 32'h0);
        apb(1'h1, 12'h068, 32'h0);
        apb(1'h1, 12'h070, 32'hff);
        apb(1'h0, 12'h080, 32'h0);
        for (k = 1; k >= 0; k--) begin
            apb(1'h1, 12'h084, 32'(k));
            rdchk(12'h084, 32'(k));
            pinsAB[1] <= ~pinsAB[1];
            repeat (6) @(posedge core_clk);
            chk(32'(irq), 32'(k));
            chk(32'(groupMgmtIrqN), 32'h0);
            // Group A still enables gpio_21, so the first pass also rises
            rdchk(12'h080, 32'h01 | 32'(k << 6));
            chk(32'(irq), 32'h0);
        end
        $display("test interrupt done");
        conclude();
    end
endmodule : sees_top_tb

bind sees_top sees_top_checker chk_u (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioGroupA(gpioGroupA), .gpioGroupB(gpioGroupB),
    .fanSpeedPulseInput(fanSpeedPulseInput), .gpioGroupC(gpioGroupC),
    .gpioGroupD(gpioGroupD), .groupMgmtIrqN(groupMgmtIrqN),
    .sourceEventBus(sourceEventBus), .irq(irq));
